// >>> verilog/lamc_cfg.svh
// Offsets, field positions, reset values and timing counts of the measurement configuration block.
// Assumes a 200 MHz aclk and register indices that sit at byte address index * 4.
`ifndef LAMC_CFG_SVH
`define LAMC_CFG_SVH

`define LAMC_IDX_AUX_SEL  6'h0F
`define LAMC_IDX_VIS_REC  6'h10
`define LAMC_IDX_VIS_GAIN 6'h11
`define LAMC_IDX_VIS_MISC 6'h12
`define LAMC_IDX_IR_REC   6'h1D
`define LAMC_IDX_IR_GAIN  6'h1E
`define LAMC_IDX_CTRL     6'h20
`define LAMC_IDX_STATUS   6'h21

`define LAMC_RST_AUX_SEL  8'h65
`define LAMC_RST_REC      8'h70
`define LAMC_RST_GAIN     8'h00
`define LAMC_RST_MISC     8'h00

`define LAMC_MASK_AUX     8'hFF
`define LAMC_MASK_REC     8'h70
`define LAMC_MASK_GAIN    8'h07
`define LAMC_MASK_MISC    8'h20

`define LAMC_REC_LSB      4
`define LAMC_RANGE_BIT    5
`define LAMC_DONE_BIT     3

`define LAMC_AUX_TEMP     8'h65
`define LAMC_AUX_VDD      8'h75

`define LAMC_CLK_NS       5
`define LAMC_CONV_NS      50
`define LAMC_CONV_CYC     ((`LAMC_CONV_NS + `LAMC_CLK_NS - 1) / `LAMC_CLK_NS)
`define LAMC_INTEG_CLKS   10'd64

`define LAMC_RESP_OKAY    2'b00
`define LAMC_RESP_SLVERR  2'b10

`endif

// >>> verilog/lamc_pkg.sv
// Types shared by the measurement configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package lamc_pkg;
  typedef enum logic [1:0] {
    LAMC_CH_VIS = 2'b00,
    LAMC_CH_IR  = 2'b01,
    LAMC_CH_AUX = 2'b10
  } lamc_chan_t;

  typedef enum logic [1:0] {
    LAMC_IDLE      = 2'b00,
    LAMC_RECOVER   = 2'b01,
    LAMC_INTEGRATE = 2'b10
  } lamc_state_t;
endpackage

// >>> verilog/lamc_conv_timer.sv
// Converter clock generator and period counter for one recovery or integration phase.
// Assumes start arrives only while busy is low; gain and clocks are sampled with start.
`timescale 1ns/100ps
`include "lamc_cfg.svh"
module lamc_conv_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic [2:0] gain,
  input  wire logic [9:0] clocks,
  output wire logic       tick,
  output logic            done,
  output logic            busy
);
  import lamc_pkg::*;

  localparam logic [10:0] BASE = 11'(`LAMC_CONV_CYC);

  logic [10:0] pre;
  logic [10:0] reload_q;
  logic [9:0]  left;
  logic [2:0]  gain_q;
  logic [9:0]  clocks_q;
  logic [10:0] gap;
  logic [9:0]  nticks;

  wire [10:0] reload = (BASE << gain) - 11'd1;

  assign tick = busy && (pre == 11'd0);

  // Converter clock is the base period stretched by two to the gain exponent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      pre      <= 11'h000;
      reload_q <= 11'h000;
      left     <= 10'h000;
      gain_q   <= 3'h0;
      clocks_q <= 10'h000;
    end else if (start) begin
      busy     <= 1'b1;
      done     <= 1'b0;
      pre      <= reload;         // [R8]
      reload_q <= reload;
      left     <= clocks;
      gain_q   <= gain;
      clocks_q <= clocks;
    end else if (tick) begin
      pre  <= reload_q;
      left <= left - 10'd1;
      busy <= (left != 10'd1);
      done <= (left == 10'd1);    // [R4] [R10]
    end else begin
      pre  <= busy ? pre - 11'd1 : pre;
      done <= 1'b0;
    end
  end

  // Checking aids only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap    <= 11'h000;
      nticks <= 10'h000;
    end else begin
      gap    <= (start || tick) ? 11'h000 : gap + 11'd1;
      nticks <= start ? 10'h000 : nticks + 10'(tick);
    end
  end

  property p_tick_gap;
    @(posedge aclk) disable iff (!aresetn)
    tick |-> gap == (BASE << gain_q) - 11'd1;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("converter tick spacing wrong"); // [R5] [R7] [R8] [R11]

  property p_done_count;
    @(posedge aclk) disable iff (!aresetn)
    $rose(done) |-> nticks == clocks_q && !busy;
  endproperty
  a_done_count: assert property (p_done_count) else $error("phase length in converter clocks wrong"); // [R4]
endmodule

// >>> verilog/lamc_top.sv
// Measurement configuration registers and converter phase sequencer with an AXI4-Lite slave.
// Assumes a 200 MHz aclk, synchronous active-low reset and a single AXI4-Lite master.
//
// Contract
// R1: aux select 0x65 temperature, 0x75 supply
// R2: auxiliary measurements referenced to ground
// R3: aux select resets to 0x65
// R4: visible recovery code gives 1..511 clocks
// R5: visible recovery clock scaled by visible gain
// R6: software should program recovery as inverted gain
// R7: visible gain lengthens integration by 2^gain
// R8: gain exponent divides the converter clock
// R9: visible range bit selects high range
// R10: infrared recovery uses same code encoding
// R11: infrared recovery clock scaled by infrared gain
// R12: both recovery registers reset to 0x70
// R13: visible gain and range reset to zero
// R14: infrared gain scales integration and recovery
// R15: reserved bits written zero and ignored
`timescale 1ns/100ps
`include "lamc_cfg.svh"
module lamc_top (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output wire logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output wire logic               s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output wire logic               s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output lamc_pkg::lamc_chan_t    adc_channel,
  output logic [7:0]              adc_input_sel,
  output logic                    adc_ref_gnd,
  output logic                    aux_route_temp,
  output logic                    aux_route_vdd,
  output logic                    adc_high_range,
  output logic                    adc_sample,
  output logic                    meas_active,
  output wire logic               adc_clk_en
);
  import lamc_pkg::*;

  logic [7:0]  aux_input_select;
  logic [7:0]  visible_recovery_register;
  logic [7:0]  visible_gain_exponent;
  logic [7:0]  visible_range_options;
  logic [7:0]  infrared_recovery_register;
  logic [7:0]  infrared_gain_exponent;
  logic        aw_held;
  logic        w_held;
  logic [5:0]  aw_idx;
  logic [7:0]  w_byte;
  logic        w_lane0;
  logic        done_flag;
  lamc_state_t state;
  lamc_state_t next_state;
  lamc_chan_t  chan;
  lamc_chan_t  next_chan;
  logic [2:0]  pending;
  logic [2:0]  next_pending;
  logic        tmr_start;
  logic        next_start;
  logic [9:0]  tmr_count;
  logic [9:0]  next_count;
  logic [2:0]  tmr_gain;
  logic [2:0]  next_gain;
  logic        meas_end;
  logic [2:0]  rest;
  wire         tmr_done;
  wire         tmr_busy;

  // Write channel: address and data are held separately, committed once both are in
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held;
  wire wr_en   = wr_fire && w_lane0;

  wire wr_aux    = wr_en && (aw_idx == `LAMC_IDX_AUX_SEL);
  wire wr_vrec   = wr_en && (aw_idx == `LAMC_IDX_VIS_REC);
  wire wr_vgain  = wr_en && (aw_idx == `LAMC_IDX_VIS_GAIN);
  wire wr_vmisc  = wr_en && (aw_idx == `LAMC_IDX_VIS_MISC);
  wire wr_irrec  = wr_en && (aw_idx == `LAMC_IDX_IR_REC);
  wire wr_irgain = wr_en && (aw_idx == `LAMC_IDX_IR_GAIN);
  wire wr_ctrl   = wr_en && (aw_idx == `LAMC_IDX_CTRL);
  wire wr_stat   = wr_en && (aw_idx == `LAMC_IDX_STATUS);

  function automatic logic idx_hit(input logic [5:0] idx);
    idx_hit = (idx >= `LAMC_IDX_AUX_SEL && idx <= `LAMC_IDX_VIS_MISC) || idx == `LAMC_IDX_IR_REC ||
              idx == `LAMC_IDX_IR_GAIN || idx == `LAMC_IDX_CTRL || idx == `LAMC_IDX_STATUS;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= 6'h00;
      w_byte       <= 8'h00;
      w_lane0      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LAMC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[7:2];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= idx_hit(aw_idx) ? `LAMC_RESP_OKAY : `LAMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only defined fields are stored, so reserved bits cannot disturb the converter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_input_select           <= `LAMC_RST_AUX_SEL;   // [R3]
      visible_recovery_register  <= `LAMC_RST_REC;       // [R12]
      infrared_recovery_register <= `LAMC_RST_REC;       // [R12]
      visible_gain_exponent      <= `LAMC_RST_GAIN;      // [R13]
      visible_range_options      <= `LAMC_RST_MISC;      // [R13]
      infrared_gain_exponent     <= `LAMC_RST_GAIN;
    end else begin
      if (wr_aux)    aux_input_select           <= w_byte & `LAMC_MASK_AUX;
      if (wr_vrec)   visible_recovery_register  <= w_byte & `LAMC_MASK_REC;   // [R15]
      if (wr_vgain)  visible_gain_exponent      <= w_byte & `LAMC_MASK_GAIN;  // [R15]
      if (wr_vmisc)  visible_range_options      <= w_byte & `LAMC_MASK_MISC;  // [R15]
      if (wr_irrec)  infrared_recovery_register <= w_byte & `LAMC_MASK_REC;   // [R15]
      if (wr_irgain) infrared_gain_exponent     <= w_byte & `LAMC_MASK_GAIN;  // [R15]
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire [7:0] status = {4'h0, done_flag, chan, meas_active};
  wire [7:0] rd_byte =
    (ar_idx == `LAMC_IDX_AUX_SEL)  ? aux_input_select :
    (ar_idx == `LAMC_IDX_VIS_REC)  ? visible_recovery_register :
    (ar_idx == `LAMC_IDX_VIS_GAIN) ? visible_gain_exponent :
    (ar_idx == `LAMC_IDX_VIS_MISC) ? visible_range_options :
    (ar_idx == `LAMC_IDX_IR_REC)   ? infrared_recovery_register :
    (ar_idx == `LAMC_IDX_IR_GAIN)  ? infrared_gain_exponent :
    (ar_idx == `LAMC_IDX_CTRL)     ? {5'h00, pending} :
    (ar_idx == `LAMC_IDX_STATUS)   ? status : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `LAMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= idx_hit(ar_idx) ? `LAMC_RESP_OKAY : `LAMC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Per channel recovery length and gain; aux uses one unscaled clock
  logic [9:0] chan_rec  [3];
  logic [2:0] chan_gain [3];
  wire  [2:0] rec_code  [2];
  assign rec_code[0]  = visible_recovery_register[`LAMC_REC_LSB +: 3];
  assign rec_code[1]  = infrared_recovery_register[`LAMC_REC_LSB +: 3];
  assign chan_gain[0] = visible_gain_exponent[2:0];     // [R5]
  assign chan_gain[1] = infrared_gain_exponent[2:0];    // [R11] [R14]
  assign chan_gain[2] = 3'h0;
  assign chan_rec[2]  = 10'd1;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rec
      // Code 0 is one clock, otherwise 2^(code+2)-1 clocks
      assign chan_rec[gi] = (rec_code[gi] == 3'h0) ? 10'd1 :
                            10'((11'd1 << ({1'b0, rec_code[gi]} + 4'd2)) - 11'd1);  // [R4] [R10]
    end
  endgenerate

  function automatic lamc_chan_t first_chan(input logic [2:0] mask);
    first_chan = mask[0] ? LAMC_CH_VIS : (mask[1] ? LAMC_CH_IR : LAMC_CH_AUX);
  endfunction

  // Starts are accepted only while idle; a start mask of zero is ignored
  wire go = wr_ctrl && (w_byte[2:0] != 3'h0) && (state == LAMC_IDLE);

  always_comb begin
    next_state   = state;
    next_chan    = chan;
    next_pending = pending;
    next_start   = 1'b0;
    next_count   = tmr_count;
    next_gain    = tmr_gain;
    meas_end     = 1'b0;
    rest         = pending;
    rest[chan]   = 1'b0;
    unique case (state)
      LAMC_IDLE: begin
        if (go) begin
          next_pending = w_byte[2:0];
          next_chan    = first_chan(w_byte[2:0]);
          next_state   = LAMC_RECOVER;
          next_start   = 1'b1;
          next_count   = chan_rec[next_chan];
          next_gain    = chan_gain[next_chan];
        end
      end
      LAMC_RECOVER: begin
        if (tmr_done) begin
          next_state = LAMC_INTEGRATE;
          next_start = 1'b1;
          next_count = `LAMC_INTEG_CLKS;                // [R7] [R14]
        end
      end
      LAMC_INTEGRATE: begin
        if (tmr_done) begin
          next_pending = rest;
          if (rest != 3'h0) begin
            next_chan  = first_chan(rest);
            next_state = LAMC_RECOVER;
            next_start = 1'b1;
            next_count = chan_rec[next_chan];
            next_gain  = chan_gain[next_chan];
          end else begin
            next_state = LAMC_IDLE;
            meas_end   = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= LAMC_IDLE;
      chan      <= LAMC_CH_VIS;
      pending   <= 3'h0;
      tmr_start <= 1'b0;
      tmr_count <= 10'h000;
      tmr_gain  <= 3'h0;
      done_flag <= 1'b0;
    end else begin
      state     <= next_state;
      chan      <= next_chan;
      pending   <= next_pending;
      tmr_start <= next_start;
      tmr_count <= next_count;
      tmr_gain  <= next_gain;
      // Completion wins over a clear in the same cycle
      done_flag <= meas_end || (done_flag && !(wr_stat && w_byte[`LAMC_DONE_BIT]));
    end
  end

  // Converter-side drive, registered and aligned with the sequencer state
  wire next_active = (next_state != LAMC_IDLE);
  wire next_aux    = next_active && (next_chan == LAMC_CH_AUX);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_channel    <= LAMC_CH_VIS;
      adc_input_sel  <= 8'h00;
      adc_ref_gnd    <= 1'b0;
      aux_route_temp <= 1'b0;
      aux_route_vdd  <= 1'b0;
      adc_high_range <= 1'b0;
      adc_sample     <= 1'b0;
      meas_active    <= 1'b0;
    end else begin
      adc_channel    <= next_chan;
      adc_input_sel  <= next_aux ? aux_input_select : 8'h00;
      adc_ref_gnd    <= next_aux;                                             // [R2]
      aux_route_temp <= next_aux && (aux_input_select == `LAMC_AUX_TEMP);    // [R1]
      aux_route_vdd  <= next_aux && (aux_input_select == `LAMC_AUX_VDD);     // [R1]
      adc_high_range <= next_active && (next_chan == LAMC_CH_VIS) &&
                        visible_range_options[`LAMC_RANGE_BIT];               // [R9]
      adc_sample     <= (state == LAMC_RECOVER) && (next_state == LAMC_INTEGRATE);
      meas_active    <= next_active;
    end
  end

  lamc_conv_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tmr_start),
    .gain    (tmr_gain),
    .clocks  (tmr_count),
    .tick    (adc_clk_en),
    .done    (tmr_done),
    .busy    (tmr_busy)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_aux_reset;
    $past(!aresetn) |-> aux_input_select == `LAMC_RST_AUX_SEL;
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("aux select reset value wrong"); // [R3]

  property p_rec_reset;
    $past(!aresetn) |-> visible_recovery_register == `LAMC_RST_REC && infrared_recovery_register == `LAMC_RST_REC;
  endproperty
  a_rec_reset: assert property (p_rec_reset) else $error("recovery reset value wrong"); // [R12]

  property p_vis_reset;
    $past(!aresetn) |-> visible_gain_exponent == 8'h00 && visible_range_options == 8'h00;
  endproperty
  a_vis_reset: assert property (p_vis_reset) else $error("visible gain or range reset wrong"); // [R13]

  property p_ref_gnd;
    meas_active && adc_channel == LAMC_CH_AUX |-> adc_ref_gnd;
  endproperty
  a_ref_gnd: assert property (p_ref_gnd) else $error("aux not referenced to ground"); // [R2]

  property p_aux_route;
    meas_active && adc_channel == LAMC_CH_AUX |->
      aux_route_temp == (aux_input_select == 8'h65) && aux_route_vdd == (aux_input_select == 8'h75);
  endproperty
  a_aux_route: assert property (p_aux_route) else $error("aux routing wrong"); // [R1]

  property p_range;
    meas_active && adc_channel == LAMC_CH_VIS |=> $past(visible_range_options[5]) == adc_high_range ||
      !meas_active || adc_channel != LAMC_CH_VIS;
  endproperty
  a_range: assert property (p_range) else $error("visible range not applied"); // [R9]

  property p_rec_load;
    tmr_start && state == LAMC_RECOVER |->
      tmr_count == chan_rec[chan] && tmr_gain == chan_gain[chan] &&
      (chan != LAMC_CH_IR || tmr_gain == infrared_gain_exponent[2:0]);
  endproperty
  a_rec_load: assert property (p_rec_load) else $error("recovery phase loaded wrongly"); // [R4] [R10] [R11] [R14]

  property p_integ_gain;
    tmr_start && state == LAMC_INTEGRATE |-> tmr_count == 10'd64 && tmr_gain == chan_gain[chan];
  endproperty
  a_integ_gain: assert property (p_integ_gain) else $error("integration not scaled by gain"); // [R7] [R14]

  sequence s_quiet_ten;
    !tmr_done[*8] ##1 !tmr_done ##1 !tmr_done;
  endsequence
  property p_one_clock;
    tmr_start && tmr_count == 10'd1 && tmr_gain == 3'h0 |=> s_quiet_ten ##1 tmr_done;
  endproperty
  a_one_clock: assert property (p_one_clock) else $error("one clock phase not 50 ns"); // [R4] [R5]

  property p_reserved;
    (visible_recovery_register & ~`LAMC_MASK_REC) == 8'h00 && (visible_gain_exponent & ~`LAMC_MASK_GAIN) == 8'h00 &&
    (visible_range_options & ~`LAMC_MASK_MISC) == 8'h00 && (infrared_recovery_register & ~`LAMC_MASK_REC) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits stored"); // [R15]
endmodule

// >>> tb/lamc_host_model.sv
// AXI4-Lite master standing in for the host that programs the measurement parameters.
// Assumes each task is entered just after a rising aclk edge and only one task runs at a time.
`timescale 1ns/100ps
module lamc_host_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Handshakes judged at the falling edge, where every slave output has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic ta;
    logic tw;
    logic fin;
    fin = 1'b0;
    resp = 2'b11;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Waits for the answer as long as it takes; the bench watchdog bounds it
    while (!fin) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      fin = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (fin) bready <= 1'b0;
    end
    // Spare edge so the next call never reassigns bready in the same step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ta;
    logic fin;
    fin = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!fin) begin
      @(negedge aclk);
      ta = arvalid && arready;
      fin = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (fin) rready <= 1'b0;
    end
    @(posedge aclk);
  endtask
endmodule

// >>> tb/tb_lamc_top.sv
// Self-checking bench: register table over AXI4-Lite, then timed measurement sequences.
// Assumes lamc_cfg.svh on the include path and the host model driving every bus input.
`timescale 1ns/100ps
`include "lamc_cfg.svh"
module tb_lamc_top;
  import lamc_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, adc_ref_gnd, aux_route_temp, aux_route_vdd;
  logic        adc_high_range, adc_sample, meas_active, adc_clk_en, gnd, tv, tt;
  logic [7:0]  awaddr, araddr, adc_input_sel, sel;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  lamc_chan_t  adc_channel;
  int          n_fail = 0, checks = 0, cyc = 0, last = 0;
  int          nt[3], gp[3], ns[3];
  logic        hi[3];

  lamc_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  lamc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .adc_channel(adc_channel),
    .adc_input_sel(adc_input_sel), .adc_ref_gnd(adc_ref_gnd), .aux_route_temp(aux_route_temp),
    .aux_route_vdd(aux_route_vdd), .adc_high_range(adc_high_range), .adc_sample(adc_sample),
    .meas_active(meas_active), .adc_clk_en(adc_clk_en));

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  // Falling-edge monitor so design updates at the rising edge never race it
  always @(negedge aclk) begin
    cyc++;
    if (meas_active) begin
      if (adc_clk_en) begin
        nt[adc_channel]++;
        gp[adc_channel] = cyc - last;
        last = cyc;
      end
      if (adc_sample) ns[adc_channel]++;
      if (adc_high_range) hi[adc_channel] = 1'b1;
      if (adc_channel == LAMC_CH_AUX) begin
        sel |= adc_input_sel;
        gnd |= adc_ref_gnd;
        tv |= aux_route_vdd;
        tt |= aux_route_temp;
      end
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int rec(input int c);
    return (c == 0) ? 1 : (1 << (c + 2)) - 1;
  endfunction

  // 50 ns converter clock at a 5 ns aclk, scaled by the gain exponent
  function automatic int per(input int g);
    return (50 / 5) << g;
  endfunction

  task automatic run(input logic [7:0] ctl);
    logic [1:0] r;
    nt = '{0, 0, 0};
    gp = '{0, 0, 0};
    ns = '{0, 0, 0};
    hi = '{1'b0, 1'b0, 1'b0};
    sel = 8'h00;
    {gnd, tv, tt} = 3'b000;
    host.wr(8'h80, ctl, r);
    chk({30'h0, r}, {30'h0, `LAMC_RESP_OKAY});
    // Only the watchdog bounds these waits
    do begin
      @(negedge aclk);
    end while (!meas_active);
    do begin
      @(negedge aclk);
    end while (meas_active);
    @(posedge aclk);
  endtask

  task automatic t_regs();
    logic [7:0]  ad[6] = '{8'h3C, 8'h40, 8'h44, 8'h48, 8'h74, 8'h78};
    logic [7:0]  rv[6] = '{8'h65, 8'h70, 8'h00, 8'h00, 8'h70, 8'h00};
    logic [7:0]  mk[6] = '{8'hFF, 8'h70, 8'h07, 8'h20, 8'h70, 8'h07};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++) begin
      host.rd(ad[i], d, r);
      chk(d, {24'h000000, rv[i]});
      host.wr(ad[i], 8'hFF, r);
      chk({30'h0, r}, {30'h0, `LAMC_RESP_OKAY});
      host.rd(ad[i], d, r);
      chk(d, {24'h000000, mk[i]});
    end
    host.rd(8'h00, d, r);
    chk(d, 32'h00000000);
    chk({30'h0, r}, {30'h0, `LAMC_RESP_SLVERR});
    host.wr(8'h04, 8'h5A, r);
    chk({30'h0, r}, {30'h0, `LAMC_RESP_SLVERR});
  endtask

  task automatic t_three();
    logic [31:0] d;
    logic [1:0]  r;
    host.wr(8'h40, 8'h10, r);
    host.wr(8'h44, 8'h02, r);
    host.wr(8'h48, 8'h20, r);
    host.wr(8'h74, 8'h30, r);
    host.wr(8'h78, 8'h01, r);
    host.wr(8'h3C, 8'h75, r);
    run(8'h07);
    chk(nt[0], rec(1) + 64);
    chk(gp[0], per(2));
    chk(nt[1], rec(3) + 64);
    chk(gp[1], per(1));
    chk(nt[2], rec(0) + 64);
    chk(gp[2], per(0));
    chk(ns[0], 1);
    chk(ns[1], 1);
    chk(ns[2], 1);
    chk({30'h0, hi[0], hi[1]}, {30'h0, 2'b10});
    chk({24'h000000, sel}, {24'h000000, 8'h75});
    chk({29'h0, tv, tt, gnd}, {29'h0, 3'b101});
    host.rd(8'h84, d, r);
    chk({31'h0, d[3]}, {31'h0, 1'b1});
  endtask

  task automatic t_temp();
    logic [31:0] d;
    logic [1:0]  r;
    host.wr(8'h84, 8'h08, r);
    host.rd(8'h84, d, r);
    chk({31'h0, d[3]}, {31'h0, 1'b0});
    host.wr(8'h44, 8'h00, r);
    host.wr(8'h40, 8'h70, r);
    host.wr(8'h48, 8'h00, r);
    host.wr(8'h3C, 8'h65, r);
    run(8'h05);
    chk(nt[0], rec(7) + 64);
    chk(gp[0], per(0));
    chk(nt[1], 0);
    chk({31'h0, hi[0]}, 32'h00000000);
    chk({24'h000000, sel}, {24'h000000, 8'h65});
    chk({29'h0, tv, tt, gnd}, {29'h0, 3'b011});
  endtask

  task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_three();
    t_temp();
    results();
  end

  // About 12k cycles expected; this allows about five times that
  initial begin
    #300000;
    n_fail++;
    results();
  end
endmodule
